/* File: logic/nbp_params.svh */
// Purpose: Timing counts, command codes and layout figures for the flash host sequencer.
// Assumes: A 40 MHz system clock.
// Notes: Times keep their own units; the cycle counts derive from them.
`ifndef NBP_PARAMS_SVH
`define NBP_PARAMS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define NBP_CLK_MHZ 40
`define NBP_T_WB_NS 100
`define NBP_T_ADL_NS 70
`define NBP_T_WHR_NS 60
`define NBP_T_RR_NS 20
`define NBP_T_R_US 25
`define NBP_T_PROG_US 700
`define NBP_T_BERS_MS 10
// Least times round up to whole cycles.
`define NBP_NS2CYC(t) (((t) * `NBP_CLK_MHZ + 999) / 1000)

// ****************************************************************
// Command codes
// ****************************************************************
`define NBP_CMD_READ1 8'h00
`define NBP_CMD_READ2 8'h30
`define NBP_CMD_PROG1 8'h80
`define NBP_CMD_PROG2 8'h10
`define NBP_CMD_ERASE1 8'h60
`define NBP_CMD_ERASE2 8'hD0
`define NBP_CMD_STATUS 8'h70

// ****************************************************************
// Array layout and policy figures
// ****************************************************************
`define NBP_PARTIAL_PROGRAM_LIMIT 4
`define NBP_ECC_CHUNK_BYTES 528
`define NBP_SPARE_COLUMN 2048
`define NBP_ERASED_BYTE 8'hFF
`define NBP_STATUS_FAIL_BIT 0
`define NBP_COL_CYCLES 2
`define NBP_ROW_CYCLES 3

`endif

/* File: logic/nbp_pkg.sv */
// Purpose: Types shared by the flash host sequencer.
// Assumes: Nothing beyond the parameter header.
// Notes: Holds types only; figures live in the header.
package nbp_pkg;

    // Operations the user may request.
    typedef enum logic [1:0] {
        NBP_OP_READ = 2'd0,
        NBP_OP_PROG = 2'd1,
        NBP_OP_ERASE = 2'd2,
        NBP_OP_SCAN = 2'd3
    } nbp_op_t;

    // Sequencer states, one-hot.
    typedef enum logic [11:0] {
        NBP_ST_IDLE = 12'b0000_0000_0001,
        NBP_ST_CMD1 = 12'b0000_0000_0010,
        NBP_ST_ADDR = 12'b0000_0000_0100,
        NBP_ST_DIN = 12'b0000_0000_1000,
        NBP_ST_CMD2 = 12'b0000_0001_0000,
        NBP_ST_WB = 12'b0000_0010_0000,
        NBP_ST_RB = 12'b0000_0100_0000,
        NBP_ST_STAT = 12'b0000_1000_0000,
        NBP_ST_SRD = 12'b0001_0000_0000,
        NBP_ST_DOUT = 12'b0010_0000_0000,
        NBP_ST_GAP = 12'b0100_0000_0000,
        NBP_ST_DONE = 12'b1000_0000_0000
    } nbp_state_t;

endpackage

/* File: logic/nbp_host.sv */
// Purpose: Host sequencer that drives an asynchronous NAND flash over its pins.
// Assumes: Pin inputs synchronous to i_mclk; one device on the bus.
// Notes: Every byte transfer takes three clock phases: writes set up, strobe low, strobe high; reads strobe low for two phases, then high.
//
// Functional notes
// - No new command within 100 ns strobe-to-busy.
// - At most four partial programs per page; the host counts them for the last programmed page only.
// - Scan markers into table before program/erase.
// - Check status after program and erase.
// - Apply ECC on every 528-byte chunk; the host computes no ECC and only marks chunk ends on read data.
// - Program pages in ascending order per block; the host checks order against the last programmed page only.
`timescale 1ns/1ps
`include "nbp_params.svh"

module nbp_host #(
    parameter int BLK_BITS = 11,
    parameter int PAGE_BITS = 6,
    parameter int READ_TMO = `NBP_T_R_US * `NBP_CLK_MHZ,
    parameter int PROG_TMO = `NBP_T_PROG_US * `NBP_CLK_MHZ,
    parameter int ERASE_TMO = `NBP_T_BERS_MS * 1000 * `NBP_CLK_MHZ
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_resetn,
    // User command port.
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_op,
    input wire logic [BLK_BITS+PAGE_BITS-1:0] i_cmd_row,
    input wire logic [11:0] i_cmd_col,
    input wire logic [11:0] i_cmd_len,
    output logic o_cmd_ready,
    output logic o_done,
    output logic o_fail,
    output logic o_refused,
    output logic o_timeout,
    // User data streams.
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_data,
    output logic o_wr_ready,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_ecc_chunk_end,
    // Flash pins.
    output logic o_chip_en_n,
    output logic o_cmd_latch,
    output logic o_addr_latch,
    output logic o_write_strobe_n,
    output logic o_read_strobe_n,
    output logic [7:0] o_io,
    output logic o_io_oe_n,
    input wire logic [7:0] i_io,
    input wire logic i_ready_busy_n
);

    localparam int ROW_BITS = BLK_BITS + PAGE_BITS;
    localparam int NBLK = 1 << BLK_BITS;
    localparam int WB_CYC = `NBP_NS2CYC(`NBP_T_WB_NS);
    localparam int ADL_CYC = `NBP_NS2CYC(`NBP_T_ADL_NS);
    localparam int WHR_CYC = `NBP_NS2CYC(`NBP_T_WHR_NS);
    localparam int RR_CYC = `NBP_NS2CYC(`NBP_T_RR_NS);

    nbp_pkg::nbp_state_t state_r;
    nbp_pkg::nbp_state_t after_gap_r;
    nbp_pkg::nbp_op_t op_r;
    logic [1:0] ph_r;
    logic [11:0] cnt_r;
    logic [11:0] len_r;
    logic [9:0] chunk_r;
    logic [19:0] tmr_r;
    logic [19:0] tmo_r;
    logic [39:0] addr_sh_r;
    logic [ROW_BITS-1:0] row_r;
    logic [NBLK-1:0] bad_r;
    logic [BLK_BITS-1:0] last_blk_r;
    logic [PAGE_BITS-1:0] last_page_r;
    logic [2:0] nop_r;
    logic last_vld_r;
    logic [7:0] io_nxt;
    logic cle_nxt;
    logic ale_nxt;
    logic we_n_nxt;
    logic re_n_nxt;
    logic oe_n_nxt;
    logic ph_end;
    logic wr_stall;
    logic refuse;
    logic [BLK_BITS-1:0] req_blk;
    logic [PAGE_BITS-1:0] req_page;
    logic [7:0] cmd2_byte;

    // ****************************************************************
    // Request screening
    // ****************************************************************
    assign req_blk = i_cmd_row[ROW_BITS-1:PAGE_BITS];
    assign req_page = i_cmd_row[PAGE_BITS-1:0];
    // A stalled data byte freezes the phase so no strobe fires without data.
    assign wr_stall = (state_r == nbp_pkg::NBP_ST_DIN) && (ph_r == 2'd0) && !i_wr_valid;
    assign ph_end = (ph_r == 2'd2);

    // Refusal keeps known-bad blocks and illegal page orders off the array.
    always_comb
    begin
        refuse = 1'b0;
        if ((i_cmd_op == nbp_pkg::NBP_OP_PROG || i_cmd_op == nbp_pkg::NBP_OP_ERASE)
            && bad_r[req_blk])
        begin
            refuse = 1'b1;
        end
        if (i_cmd_op == nbp_pkg::NBP_OP_PROG && last_vld_r && req_blk == last_blk_r)
        begin
            if (req_page < last_page_r)
            begin
                refuse = 1'b1;
            end
            if (req_page == last_page_r && nop_r == 3'(`NBP_PARTIAL_PROGRAM_LIMIT))
            begin
                refuse = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    assign cmd2_byte = (op_r == nbp_pkg::NBP_OP_PROG) ? `NBP_CMD_PROG2 :
                       (op_r == nbp_pkg::NBP_OP_ERASE) ? `NBP_CMD_ERASE2 : `NBP_CMD_READ2;

    // Main state walk; the busy wait is always bounded by the operation's worst case.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_r <= nbp_pkg::NBP_ST_IDLE;
            after_gap_r <= nbp_pkg::NBP_ST_IDLE;
            op_r <= nbp_pkg::NBP_OP_READ;
            ph_r <= 2'd0;
            cnt_r <= 12'h000;
            len_r <= 12'h000;
            tmr_r <= 20'h0_0000;
            tmo_r <= 20'h0_0000;
            addr_sh_r <= 40'h00_0000_0000;
            row_r <= '0;
        end
        else
        begin
            // Phase runs only in pin states, so each byte starts at phase zero.
            ph_r <= (!(|(state_r & 12'h039E)) || wr_stall || ph_end) ? 2'd0 : ph_r + 2'd1;
            case (state_r)
                nbp_pkg::NBP_ST_IDLE:
                begin
                    if (i_cmd_valid && !refuse)
                    begin
                        op_r <= nbp_pkg::nbp_op_t'(i_cmd_op);
                        row_r <= i_cmd_row;
                        len_r <= (i_cmd_op == nbp_pkg::NBP_OP_SCAN) ? 12'h001 : i_cmd_len;
                        cnt_r <= 12'h000;
                        if (i_cmd_op == nbp_pkg::NBP_OP_ERASE)
                        begin
                            addr_sh_r <= {16'h0000, 24'(i_cmd_row)};
                        end
                        else if (i_cmd_op == nbp_pkg::NBP_OP_SCAN)
                        begin
                            addr_sh_r <= {24'(i_cmd_row), 16'(`NBP_SPARE_COLUMN)};
                        end
                        else
                        begin
                            addr_sh_r <= {24'(i_cmd_row), 4'h0, i_cmd_col};
                        end
                        case (nbp_pkg::nbp_op_t'(i_cmd_op))
                            nbp_pkg::NBP_OP_ERASE: tmo_r <= 20'(ERASE_TMO);
                            nbp_pkg::NBP_OP_PROG: tmo_r <= 20'(PROG_TMO);
                            default: tmo_r <= 20'(READ_TMO);
                        endcase
                        state_r <= nbp_pkg::NBP_ST_CMD1;
                    end
                end
                nbp_pkg::NBP_ST_CMD1:
                begin
                    if (ph_end)
                    begin
                        state_r <= nbp_pkg::NBP_ST_ADDR;
                    end
                end
                nbp_pkg::NBP_ST_ADDR:
                begin
                    if (ph_end)
                    begin
                        addr_sh_r <= addr_sh_r >> 8;
                        cnt_r <= cnt_r + 12'h001;
                        if (cnt_r == ((op_r == nbp_pkg::NBP_OP_ERASE) ?
                            12'(`NBP_ROW_CYCLES - 1) :
                            12'(`NBP_COL_CYCLES + `NBP_ROW_CYCLES - 1)))
                        begin
                            cnt_r <= 12'h000;
                            if (op_r == nbp_pkg::NBP_OP_PROG)
                            begin
                                tmr_r <= 20'(ADL_CYC);
                                after_gap_r <= nbp_pkg::NBP_ST_DIN;
                                state_r <= nbp_pkg::NBP_ST_GAP;
                            end
                            else
                            begin
                                state_r <= nbp_pkg::NBP_ST_CMD2;
                            end
                        end
                    end
                end
                nbp_pkg::NBP_ST_DIN:
                begin
                    if (ph_end)
                    begin
                        cnt_r <= cnt_r + 12'h001;
                        if (cnt_r + 12'h001 >= len_r)
                        begin
                            state_r <= nbp_pkg::NBP_ST_CMD2;
                        end
                    end
                end
                nbp_pkg::NBP_ST_CMD2:
                begin
                    if (ph_end)
                    begin
                        tmr_r <= 20'(WB_CYC);
                        state_r <= nbp_pkg::NBP_ST_WB;
                    end
                end
                nbp_pkg::NBP_ST_WB:
                begin
                    // Ready/busy is blind until busy can have asserted.
                    tmr_r <= tmr_r - 20'h0_0001;
                    if (tmr_r == 20'h0_0001)
                    begin
                        tmr_r <= tmo_r;
                        state_r <= nbp_pkg::NBP_ST_RB;
                    end
                end
                nbp_pkg::NBP_ST_RB:
                begin
                    tmr_r <= tmr_r - 20'h0_0001;
                    if (i_ready_busy_n)
                    begin
                        cnt_r <= 12'h000;
                        if (op_r == nbp_pkg::NBP_OP_PROG || op_r == nbp_pkg::NBP_OP_ERASE)
                        begin
                            state_r <= nbp_pkg::NBP_ST_STAT;
                        end
                        else
                        begin
                            tmr_r <= 20'(RR_CYC);
                            after_gap_r <= nbp_pkg::NBP_ST_DOUT;
                            state_r <= nbp_pkg::NBP_ST_GAP;
                        end
                    end
                    else if (tmr_r == 20'h0_0000)
                    begin
                        state_r <= nbp_pkg::NBP_ST_DONE;
                    end
                end
                nbp_pkg::NBP_ST_STAT:
                begin
                    if (ph_end)
                    begin
                        tmr_r <= 20'(WHR_CYC);
                        after_gap_r <= nbp_pkg::NBP_ST_SRD;
                        state_r <= nbp_pkg::NBP_ST_GAP;
                    end
                end
                nbp_pkg::NBP_ST_SRD:
                begin
                    if (ph_end)
                    begin
                        state_r <= nbp_pkg::NBP_ST_DONE;
                    end
                end
                nbp_pkg::NBP_ST_DOUT:
                begin
                    if (ph_end)
                    begin
                        cnt_r <= cnt_r + 12'h001;
                        if (cnt_r + 12'h001 >= len_r)
                        begin
                            state_r <= nbp_pkg::NBP_ST_DONE;
                        end
                    end
                end
                nbp_pkg::NBP_ST_GAP:
                begin
                    tmr_r <= tmr_r - 20'h0_0001;
                    if (tmr_r <= 20'h0_0001)
                    begin
                        state_r <= after_gap_r;
                    end
                end
                nbp_pkg::NBP_ST_DONE:
                begin
                    state_r <= nbp_pkg::NBP_ST_IDLE;
                end
                default:
                begin
                    state_r <= nbp_pkg::NBP_ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Next pin levels by state and phase; pins are then registered.
    always_comb
    begin
        io_nxt = 8'h00;
        cle_nxt = 1'b0;
        ale_nxt = 1'b0;
        we_n_nxt = 1'b1;
        re_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        case (state_r)
            nbp_pkg::NBP_ST_CMD1, nbp_pkg::NBP_ST_CMD2, nbp_pkg::NBP_ST_STAT:
            begin
                cle_nxt = 1'b1;
                oe_n_nxt = 1'b0;
                we_n_nxt = (ph_r != 2'd1);
                io_nxt = (state_r == nbp_pkg::NBP_ST_STAT) ? `NBP_CMD_STATUS :
                         (state_r == nbp_pkg::NBP_ST_CMD2) ? cmd2_byte :
                         (op_r == nbp_pkg::NBP_OP_PROG) ? `NBP_CMD_PROG1 :
                         (op_r == nbp_pkg::NBP_OP_ERASE) ? `NBP_CMD_ERASE1 : `NBP_CMD_READ1;
            end
            nbp_pkg::NBP_ST_ADDR:
            begin
                ale_nxt = 1'b1;
                oe_n_nxt = 1'b0;
                we_n_nxt = (ph_r != 2'd1);
                io_nxt = addr_sh_r[7:0];
            end
            nbp_pkg::NBP_ST_DIN:
            begin
                oe_n_nxt = 1'b0;
                we_n_nxt = !(ph_r == 2'd1);
                io_nxt = o_io;
            end
            nbp_pkg::NBP_ST_SRD, nbp_pkg::NBP_ST_DOUT:
            begin
                re_n_nxt = (ph_r == 2'd2);
            end
            default:
            begin
                io_nxt = 8'h00;
            end
        endcase
    end

    // Registered pins; the data byte is captured when the user hands it over.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_chip_en_n <= 1'b1;
            o_cmd_latch <= 1'b0;
            o_addr_latch <= 1'b0;
            o_write_strobe_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_io <= 8'h00;
            o_io_oe_n <= 1'b1;
            o_wr_ready <= 1'b0;
        end
        else
        begin
            o_chip_en_n <= (state_r == nbp_pkg::NBP_ST_IDLE) || (state_r == nbp_pkg::NBP_ST_DONE);
            o_cmd_latch <= cle_nxt;
            o_addr_latch <= ale_nxt;
            o_write_strobe_n <= we_n_nxt;
            o_read_strobe_n <= re_n_nxt;
            o_io_oe_n <= oe_n_nxt;
            o_wr_ready <= 1'b0;
            if (state_r == nbp_pkg::NBP_ST_DIN && ph_r == 2'd0 && i_wr_valid)
            begin
                o_io <= i_wr_data;
                o_wr_ready <= 1'b1;
            end
            else
            begin
                o_io <= io_nxt;
            end
        end
    end

    // ****************************************************************
    // Results, read data and ECC framing
    // ****************************************************************
    // Answers to the user; the refusal answer is given without touching the pins.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_cmd_ready <= 1'b0;
            o_done <= 1'b0;
            o_fail <= 1'b0;
            o_refused <= 1'b0;
            o_timeout <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            o_ecc_chunk_end <= 1'b0;
            chunk_r <= 10'h000;
        end
        else
        begin
            o_cmd_ready <= (state_r == nbp_pkg::NBP_ST_IDLE) && !i_cmd_valid;
            o_done <= (state_r == nbp_pkg::NBP_ST_DONE) ||
                      (state_r == nbp_pkg::NBP_ST_IDLE && i_cmd_valid && refuse);
            o_refused <= (state_r == nbp_pkg::NBP_ST_IDLE) && i_cmd_valid && refuse;
            if (state_r == nbp_pkg::NBP_ST_IDLE && i_cmd_valid)
            begin
                o_fail <= 1'b0;
                o_timeout <= 1'b0;
                chunk_r <= 10'h000;
            end
            if (state_r == nbp_pkg::NBP_ST_RB && !i_ready_busy_n && tmr_r == 20'h0_0000)
            begin
                o_timeout <= 1'b1;
                o_fail <= 1'b1;
            end
            if (state_r == nbp_pkg::NBP_ST_SRD && ph_end)
            begin
                o_fail <= i_io[`NBP_STATUS_FAIL_BIT];
            end
            o_rd_valid <= (state_r == nbp_pkg::NBP_ST_DOUT) && ph_end;
            o_ecc_chunk_end <= 1'b0;
            if (state_r == nbp_pkg::NBP_ST_DOUT && ph_end)
            begin
                o_rd_data <= i_io;
                // Marks each codeword boundary for the user's corrector.
                chunk_r <= (chunk_r == 10'(`NBP_ECC_CHUNK_BYTES - 1)) ? 10'h000 : chunk_r + 10'h001;
                o_ecc_chunk_end <= (chunk_r == 10'(`NBP_ECC_CHUNK_BYTES - 1));
            end
        end
    end

    // ****************************************************************
    // Block policy tables
    // ****************************************************************
    // Bad-block table fed by factory markers and by failed status reads.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            bad_r <= '0;
        end
        else if (state_r == nbp_pkg::NBP_ST_DOUT && ph_end && op_r == nbp_pkg::NBP_OP_SCAN
                 && i_io != `NBP_ERASED_BYTE)
        begin
            bad_r[row_r[ROW_BITS-1:PAGE_BITS]] <= 1'b1;
        end
        else if (state_r == nbp_pkg::NBP_ST_SRD && ph_end && i_io[`NBP_STATUS_FAIL_BIT])
        begin
            bad_r[row_r[ROW_BITS-1:PAGE_BITS]] <= 1'b1;
        end
    end

    // Last programmed page and its partial program count; an erase of that block clears it.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            last_vld_r <= 1'b0;
            last_blk_r <= '0;
            last_page_r <= '0;
            nop_r <= 3'd0;
        end
        else if (state_r == nbp_pkg::NBP_ST_IDLE && i_cmd_valid && !refuse)
        begin
            if (i_cmd_op == nbp_pkg::NBP_OP_PROG)
            begin
                last_vld_r <= 1'b1;
                last_blk_r <= req_blk;
                last_page_r <= req_page;
                nop_r <= (last_vld_r && req_blk == last_blk_r && req_page == last_page_r) ?
                         nop_r + 3'd1 : 3'd1;
            end
            else if (i_cmd_op == nbp_pkg::NBP_OP_ERASE && req_blk == last_blk_r)
            begin
                last_vld_r <= 1'b0;
            end
        end
    end

endmodule

/* File: test/nbp_host_monitor.sv */
// Purpose: Pin and handshake checks on the flash host.
// Assumes: Bound to nbp_host.
// Notes: One clock domain.
`timescale 1ns/1ps
module nbp_host_monitor (
    // Clock, reset and user status.
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic o_done,
    input wire logic o_fail,
    input wire logic o_refused,
    input wire logic o_timeout,
    input wire logic o_rd_valid,
    input wire logic o_ecc_chunk_end,
    // Flash pins.
    input wire logic o_cmd_latch,
    input wire logic o_write_strobe_n,
    input wire logic o_read_strobe_n,
    input wire logic [7:0] o_io,
    input wire logic o_io_oe_n,
    input wire logic i_ready_busy_n
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    a_refuse_with_done: assert property (
        o_refused |-> o_done) else $error("refusal without done");
    a_refused_quiet: assert property (
        o_refused |-> o_write_strobe_n && $past(o_write_strobe_n)) else $error("refused but strobed");
    a_done_single: assert property (
        o_done |=> !o_done) else $error("done too long");
    a_timeout_fail: assert property (
        o_timeout |-> o_fail) else $error("timeout without fail");
    a_chunk_with_data: assert property (
        o_ecc_chunk_end |-> o_rd_valid) else $error("chunk end without data");
    a_busy_quiet: assert property (
        !i_ready_busy_n && !o_timeout |-> o_write_strobe_n && o_read_strobe_n)
        else $error("strobe while busy");
    // A confirm must be followed by a strobe-free stretch while busy rises.
    a_wb_gap: assert property (
        $rose(o_write_strobe_n) && o_cmd_latch && (o_io == 8'h30 || o_io == 8'h10
        || o_io == 8'hD0) |=> o_write_strobe_n [*4]) else $error("strobe in busy delay");
    a_read_released: assert property (
        !o_read_strobe_n |-> o_io_oe_n) else $error("bus driven while reading");
endmodule

bind nbp_host nbp_host_monitor nbp_host_monitor_i (.*);

/* File: test/nbp_flash_model.sv */
// Purpose: Behavioural flash device facing the host pins.
// Assumes: Pins sampled on the host clock.
// Notes: Busy is shortened; one factory bad block.
`timescale 1ns/1ps
module nbp_flash_model #(
    parameter int BUSY = 20,
    parameter logic [10:0] BAD = 11'h005
) (
    // Host pins and test controls.
    input wire logic i_mclk,
    input wire logic i_cmd_latch,
    input wire logic i_addr_latch,
    input wire logic i_write_strobe_n,
    input wire logic i_read_strobe_n,
    input wire logic [7:0] i_io,
    input wire logic i_stuck,
    input wire logic i_fail,
    // Device outputs.
    output logic [7:0] o_io,
    output logic o_ready_busy_n
);
    logic [7:0] cmd_r, dat;
    logic [39:0] adr_r;
    logic [2:0] acnt_r;
    logic [11:0] col_r;
    logic [7:0] busy_r = 8'h00;
    logic we_q = 1'b1;
    logic re_q = 1'b1;
    // Spare byte holds the marker; good blocks read erased.
    assign dat = cmd_r == 8'h70 ? {7'h70, i_fail} : col_r == 12'h800 ?
        (adr_r[32:22] == BAD ? 8'h00 : 8'hFF) : adr_r[23:16] ^ col_r[7:0] ^ 8'h5A;
    // A released bus shows the inverse so a stale byte cannot pass.
    assign o_io = !i_read_strobe_n ? dat : ~dat;
    assign o_ready_busy_n = busy_r == 8'h00;
    // Strobe rises latch commands and addresses; confirms start busy.
    always_ff @(posedge i_mclk)
    begin
        we_q <= i_write_strobe_n;
        re_q <= i_read_strobe_n;
        if (busy_r != 8'h00 && !i_stuck)
            busy_r <= busy_r - 8'h01;
        if (!we_q && i_write_strobe_n && i_cmd_latch)
        begin
            cmd_r <= i_io;
            acnt_r <= 3'd0;
            col_r <= adr_r[11:0];
            if (i_io == 8'h30 || i_io == 8'h10 || i_io == 8'hD0)
                busy_r <= 8'(BUSY);
        end
        if (!we_q && i_write_strobe_n && i_addr_latch)
        begin
            adr_r[{acnt_r, 3'b000} +: 8] <= i_io;
            acnt_r <= acnt_r + 3'd1;
        end
        if (!re_q && i_read_strobe_n)
            col_r <= col_r + 12'd1;
    end
endmodule

/* File: test/nbp_host_tb.sv */
// Purpose: Self-checking bench for the flash host.
// Assumes: Shortened busy bounds.
// Notes: Fixed seed.
`timescale 1ns/1ps
module nbp_host_tb;
    localparam logic [10:0] BAD = 11'h005;
    logic i_mclk = 0, i_resetn = 0, i_cmd_valid = 0, i_wr_valid = 0, stuck = 0, pfail = 0;
    logic [1:0] i_cmd_op = 0;
    logic [16:0] i_cmd_row = 0;
    logic [11:0] i_cmd_col = 0, i_cmd_len = 1;
    logic [7:0] i_wr_data = 0, io_dev, o_rd_data, o_io;
    logic o_done, o_fail, o_refused, o_timeout, o_rd_valid, o_chunk, ce_n, cle, ale, we_n, re_n;
    logic rb_n;
    int fail_count = 0, compares = 0, col, nrd;

    nbp_host #(.READ_TMO(50), .PROG_TMO(200), .ERASE_TMO(400)) nbp_host_i (.i_mclk(i_mclk),
        .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
        .i_cmd_row(i_cmd_row), .i_cmd_col(i_cmd_col), .i_cmd_len(i_cmd_len), .o_cmd_ready(),
        .o_done(o_done), .o_fail(o_fail), .o_refused(o_refused), .o_timeout(o_timeout),
        .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_ecc_chunk_end(o_chunk), .o_chip_en_n(ce_n), .o_cmd_latch(cle),
        .o_addr_latch(ale), .o_write_strobe_n(we_n), .o_read_strobe_n(re_n), .o_io(o_io),
        .o_io_oe_n(), .i_io(io_dev), .i_ready_busy_n(rb_n));
    nbp_flash_model #(.BAD(BAD)) nbp_flash_model_i (.i_mclk(i_mclk), .i_cmd_latch(cle),
        .i_addr_latch(ale), .i_write_strobe_n(we_n), .i_read_strobe_n(re_n), .i_io(o_io),
        .i_stuck(stuck), .i_fail(pfail), .o_io(io_dev), .o_ready_busy_n(rb_n));

    // Clock at 40 MHz.
    initial forever #12.5 i_mclk = ~i_mclk;

    function automatic logic [7:0] exp_byte(logic [16:0] r, logic [11:0] c);
        if (c == 12'h800)
            return r[16:6] == BAD ? 8'h00 : 8'hFF;
        return r[7:0] ^ c[7:0] ^ 8'h5A;
    endfunction

    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        compares++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One request, dropped once taken so it is not taken twice.
    task automatic op(logic [1:0] o, logic [16:0] r, logic [11:0] c, logic [11:0] n,
        logic rf, logic fl);
        int t = 0;
        @(posedge i_mclk);
        {i_cmd_op, i_cmd_row, i_cmd_col, i_cmd_len, i_cmd_valid} <= {o, r, c, n, 1'b1};
        col = o == 2'd3 ? 2048 : c;
        nrd = 0;
        @(posedge i_mclk);
        i_cmd_valid <= 1'b0;
        do @(posedge i_mclk); while (o_done !== 1'b1 && ++t < 2000);
        chk("done", 1, o_done);
        chk("refused", rf, o_refused);
        chk("fail", fl, o_fail);
    endtask

    // Read bytes are checked away from the edge.
    always @(negedge i_mclk)
        if (o_rd_valid === 1'b1)
        begin
            nrd++;
            chk("rd_data", exp_byte(i_cmd_row, 12'(col)), o_rd_data);
            chk("chunk_end", nrd % 528 == 0, o_chunk);
            col++;
        end

    // Program data is offered with random stalls.
    always @(posedge i_mclk)
    begin
        i_wr_data <= 8'($urandom);
        i_wr_valid <= $urandom % 4 != 0;
    end

    task automatic results();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge i_mclk);
        fail_count++;
        results();
    end

    initial
    begin
        void'($urandom(60476));
        repeat (12) @(posedge i_mclk);
        i_resetn <= 1'b1;
        op(3, 17'd0, 0, 1, 0, 0);
        op(3, {BAD, 6'd1}, 0, 1, 0, 0);
        op(1, {BAD, 6'd0}, 0, 4, 1, 0);
        op(2, {BAD, 6'd0}, 0, 1, 1, 0);
        repeat (4) op(0, 17'($urandom), 12'($urandom % 2048), 12'(1 + $urandom % 8), 0, 0);
        op(0, 17'd70, 0, 12'd530, 0, 0);
        repeat (4) op(1, {11'd1, 6'd3}, 0, 2, 0, 0);
        op(1, {11'd1, 6'd3}, 0, 2, 1, 0);
        op(1, {11'd1, 6'd4}, 0, 2, 0, 0);
        op(1, {11'd1, 6'd2}, 0, 2, 1, 0);
        op(2, {11'd1, 6'd0}, 0, 1, 0, 0);
        op(1, {11'd1, 6'd2}, 0, 2, 0, 0);
        pfail <= 1'b1;
        op(1, {11'd2, 6'd0}, 0, 1, 0, 1);
        pfail <= 1'b0;
        stuck <= 1'b1;
        op(2, {11'd3, 6'd0}, 0, 1, 0, 1);
        chk("timeout", 1, o_timeout);
        stuck <= 1'b0;
        repeat (30) @(posedge i_mclk);
        op(3, {11'd4, 6'd0}, 0, 1, 0, 0);
        results();
    end
endmodule
